// [common/clg_regs.svh]
`ifndef CLG_REGS_SVH
`define CLG_REGS_SVH

`define CLG_CFG_BASE     8'h00
`define CLG_DLY_BASE     8'h10
`define CLG_STAT_ADDR    8'h20
`define CLG_SRC_ADDR     8'h24
`define CLG_ELAP_BASE    8'h30

`define CLG_CFG_FUNC_LSB 0
`define CLG_CFG_INVA_BIT 2
`define CLG_CFG_INVB_BIT 3
`define CLG_CFG_SRCA_LSB 8
`define CLG_CFG_SRCB_LSB 16
`define CLG_CFG_MASK     32'h001F1F0F
`define CLG_DLY_MASK     32'h0000007F

`define CLG_CFG_RESET    32'h00000000
`define CLG_DLY_RESET    32'h00000000

`define CLG_DLY_MAX_S    7'h78
`define CLG_TICK_S       1
`define CLG_CLK_NS       25
`define CLG_TICK_CYCLES  ((`CLG_TICK_S * 1000000000) / `CLG_CLK_NS)

`define CLG_RESP_OKAY    2'h0
`define CLG_RESP_SLVERR  2'h2

`endif

// [common/clg_pkg.sv]
package clg_pkg;

    localparam int GATES  = 4;
    localparam int SRCS   = 32;
    localparam int SEL_W  = 5;
    localparam int DLY_W  = 7;
    localparam int PRES_W = 26;

    typedef enum logic [1:0] {
        CLG_FN_NONE  = 2'h0,
        CLG_FN_AND   = 2'h1,
        CLG_FN_OR    = 2'h2,
        CLG_FN_LATCH = 2'h3
    } clg_func_t;

    typedef struct packed {
        logic [SEL_W-1:0] srcB;
        logic [SEL_W-1:0] srcA;
        logic             invB;
        logic             invA;
        clg_func_t        func;
    } clg_cfg_t;

    typedef struct packed {
        logic             gateOut;
        logic             latchState;
        logic             result;
        logic [DLY_W-1:0] elapsed;
    } clg_stat_t;

endpackage

// [core/clg_gate_cell.sv]
`timescale 1ns/1ps
`include "clg_regs.svh"

module clg_gate_cell #(
    parameter int TICK_CYCLES = `CLG_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // Selected sources and settings
    input  wire logic                      srcA,
    input  wire logic                      srcB,
    input  wire clg_pkg::clg_cfg_t         cfg,
    input  wire logic [clg_pkg::DLY_W-1:0] delaySec,
    // State
    output clg_pkg::clg_stat_t             stat
);

    localparam logic [clg_pkg::PRES_W-1:0] TICK_LAST =
        clg_pkg::PRES_W'(TICK_CYCLES - 1);

    logic                      effA;
    logic                      effB;
    logic                      result;
    logic                      latchState;
    logic                      gateOut;
    logic [clg_pkg::DLY_W-1:0] limit;
    logic [clg_pkg::DLY_W-1:0] seconds;
    logic [clg_pkg::PRES_W-1:0] prescale;

    assign effA  = srcA ^ cfg.invA;
    assign effB  = srcB ^ cfg.invB;
    assign limit = (delaySec > `CLG_DLY_MAX_S) ? `CLG_DLY_MAX_S : delaySec;

    always_comb begin
        case (cfg.func)
            clg_pkg::CLG_FN_AND:   result = effA & effB;
            clg_pkg::CLG_FN_OR:    result = effA | effB;
            clg_pkg::CLG_FN_LATCH: begin
                if (effA)
                    result = 1'b1;
                else if (effB)
                    result = 1'b0;
                else
                    result = latchState;
            end
            default:               result = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            latchState <= 1'b0;
        else if (cfg.func == clg_pkg::CLG_FN_LATCH) begin
            if (effA)
                latchState <= 1'b1;
            else if (effB)
                latchState <= 1'b0;
        end
    end

    // Whole seconds since the result became true, counting up to the delay limit and holding there
    always_ff @(posedge core_clk) begin
        if (rst || !result) begin
            prescale <= '0;
            seconds  <= '0;
        end else if (seconds < limit) begin
            if (prescale == TICK_LAST) begin
                prescale <= '0;
                seconds  <= seconds + 1'b1;
            end else begin
                prescale <= prescale + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            gateOut <= 1'b0;
        else
            gateOut <= result && (seconds >= limit);
    end

    assign stat.gateOut    = gateOut;
    assign stat.latchState = latchState;
    assign stat.result     = result;
    assign stat.elapsed    = seconds;

endmodule

// [core/clg_gates.sv]
`timescale 1ns/1ps
`include "clg_regs.svh"

module clg_gates #(
    parameter int TICK_CYCLES = `CLG_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // Digital signal sources
    input  wire logic [clg_pkg::SRCS-1:0] srcBus,
    // Gate outputs
    output logic [clg_pkg::GATES-1:0]     gateOut,
    // AXI4-Lite write address
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);

    localparam int G = clg_pkg::GATES;

    logic [31:0]        cfgWord [G];
    logic [31:0]        dlyWord [G];
    clg_pkg::clg_cfg_t  cfg     [G];
    clg_pkg::clg_stat_t stat    [G];

    logic [7:0]  wAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awHeld;
    logic        wHeld;
    logic        writeFire;

    // Source picker, used for both inputs of every gate
    function automatic logic pickSource(input logic [clg_pkg::SRCS-1:0] bus,
                                        input logic [clg_pkg::SEL_W-1:0] sel);
        pickSource = bus[sel];
    endfunction

    function automatic clg_pkg::clg_cfg_t decodeCfg(input logic [31:0] word);
        clg_pkg::clg_cfg_t c;
        c.func = clg_pkg::clg_func_t'(word[`CLG_CFG_FUNC_LSB +: 2]);
        c.invA = word[`CLG_CFG_INVA_BIT];
        c.invB = word[`CLG_CFG_INVB_BIT];
        c.srcA = word[`CLG_CFG_SRCA_LSB +: clg_pkg::SEL_W];
        c.srcB = word[`CLG_CFG_SRCB_LSB +: clg_pkg::SEL_W];
        decodeCfg = c;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] mergeWrite(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] merged;
        merged = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                merged[i*8 +: 8] = data[i*8 +: 8];
        end
        mergeWrite = merged & mask;
    endfunction

    function automatic logic isWritable(input logic [7:0] addr);
        isWritable = (addr[1:0] == 2'h0) &&
                     (addr >= `CLG_CFG_BASE) &&
                     (addr < (`CLG_DLY_BASE + 8'(4 * G)));
    endfunction

    // Gate instances
    genvar g;
    generate
        for (g = 0; g < G; g++) begin : gen_gate
            assign cfg[g] = decodeCfg(cfgWord[g]);

            clg_gate_cell #(
                .TICK_CYCLES (TICK_CYCLES)
            ) u_cell (
                .core_clk (core_clk),
                .rst      (rst),
                .srcA     (pickSource(srcBus, cfg[g].srcA)),
                .srcB     (pickSource(srcBus, cfg[g].srcB)),
                .cfg      (cfg[g]),
                .delaySec (dlyWord[g][clg_pkg::DLY_W-1:0]),
                .stat     (stat[g])
            );

            always_ff @(posedge core_clk) begin
                if (rst)
                    cfgWord[g] <= `CLG_CFG_RESET;
                else if (writeFire && wAddr == (`CLG_CFG_BASE + 8'(4 * g)))
                    cfgWord[g] <= mergeWrite(cfgWord[g], wData, wStrb, `CLG_CFG_MASK);
            end

            always_ff @(posedge core_clk) begin
                if (rst)
                    dlyWord[g] <= `CLG_DLY_RESET;
                else if (writeFire && wAddr == (`CLG_DLY_BASE + 8'(4 * g)))
                    dlyWord[g] <= mergeWrite(dlyWord[g], wData, wStrb, `CLG_DLY_MASK);
            end

            assign gateOut[g] = stat[g].gateOut;
        end
    endgenerate

    // Read-side decode
    function automatic logic [33:0] readWord(input logic [7:0] addr);
        logic [31:0] data;
        logic [1:0]  resp;
        data = 32'h00000000;
        resp = `CLG_RESP_SLVERR;
        if (addr[1:0] == 2'h0) begin
            for (int i = 0; i < G; i++) begin
                if (addr == (`CLG_CFG_BASE + 8'(4 * i))) begin
                    data = cfgWord[i];
                    resp = `CLG_RESP_OKAY;
                end
                if (addr == (`CLG_DLY_BASE + 8'(4 * i))) begin
                    data = dlyWord[i];
                    resp = `CLG_RESP_OKAY;
                end
                if (addr == (`CLG_ELAP_BASE + 8'(4 * i))) begin
                    data[clg_pkg::DLY_W-1:0] = stat[i].elapsed;
                    resp = `CLG_RESP_OKAY;
                end
            end
            if (addr == `CLG_STAT_ADDR) begin
                for (int i = 0; i < G; i++) begin
                    data[i]     = stat[i].gateOut;
                    data[4 + i] = stat[i].latchState;
                    data[8 + i] = stat[i].result;
                end
                resp = `CLG_RESP_OKAY;
            end
            if (addr == `CLG_SRC_ADDR) begin
                data = srcBus;
                resp = `CLG_RESP_OKAY;
            end
        end
        readWord = {resp, data};
    endfunction

    assign writeFire = awHeld && wHeld && !s_axi_bvalid;

    // Write address channel
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            awHeld        <= 1'b0;
            wAddr         <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awHeld        <= 1'b1;
            wAddr         <= s_axi_awaddr;
        end else if (writeFire) begin
            awHeld        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_wready <= 1'b1;
            wHeld        <= 1'b0;
            wData        <= 32'h00000000;
            wStrb        <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wHeld        <= 1'b1;
            wData        <= s_axi_wdata;
            wStrb        <= s_axi_wstrb;
        end else if (writeFire) begin
            wHeld        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CLG_RESP_OKAY;
        end else if (writeFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= isWritable(wAddr) ? `CLG_RESP_OKAY : `CLG_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CLG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready               <= 1'b0;
            s_axi_rvalid                <= 1'b1;
            {s_axi_rresp, s_axi_rdata}  <= readWord(s_axi_araddr);
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// [dv/clg_gates_props.sv]
`timescale 1ns/1ps

module clg_gates_props #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst,
    // Gate outputs
    input wire logic [clg_pkg::GATES-1:0] gateOut,
    // Write channels
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    // Read channels
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic [1:0]               s_axi_rresp,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_reset_idle: assert property ($fell(rst) |-> gateOut == 4'h0 && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    chk_b_after_wr: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("no write response");
    chk_r_after_rd: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read data");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    chk_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during data");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
    chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write ready not back");
endmodule

bind clg_gates clg_gates_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// [dv/clg_src_model.sv]
`timescale 1ns/1ps

module clg_src_model (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Levels requested by the bench
    input wire logic [31:0] pattern,
    // Source levels toward the gates
    output logic     [31:0] srcBus
);
    // Source levels change only on a clock edge
    always_ff @(posedge core_clk) begin
        srcBus <= rst ? 32'h0 : pattern;
    end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps

module tb;
    localparam int TICK = 4;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] pattern = 32'h0, srcBus, wData = 32'h0, rData, rd, seed = 32'h276B964A;
    logic [7:0] awAddr = 8'h0, arAddr = 8'h0;
    logic [3:0] gateOut;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, ea, eb, res;
    logic [1:0] bResp, rResp, rsp;
    int fail_count = 0;
    int checks = 0;
    int n;
    int cnt [4] = '{0, 0, 0, 0};
    logic refOut [4] = '{0, 0, 0, 0};
    logic refSt [4] = '{0, 0, 0, 0};
    logic [6:0] shDly [4] = '{0, 0, 0, 0};
    clg_pkg::clg_cfg_t shCfg [4] = '{'0, '0, '0, '0};

    always #12.5 core_clk = ~core_clk;

    clg_src_model u_src (.core_clk(core_clk), .rst(rst), .pattern(pattern), .srcBus(srcBus));
    clg_gates #(.TICK_CYCLES(TICK)) u_dut (.core_clk(core_clk), .rst(rst), .srcBus(srcBus),
        .gateOut(gateOut), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference gates, fed from the shadow settings
    always @(posedge core_clk) begin
        for (int g = 0; g < 4; g++) begin
            ea = srcBus[shCfg[g].srcA] ^ shCfg[g].invA;
            eb = srcBus[shCfg[g].srcB] ^ shCfg[g].invB;
            case (shCfg[g].func)
                clg_pkg::CLG_FN_AND: res = ea & eb;
                clg_pkg::CLG_FN_OR: res = ea | eb;
                clg_pkg::CLG_FN_LATCH: res = ea | (~eb & refSt[g]);
                default: res = 1'b0;
            endcase
            if (shCfg[g].func == clg_pkg::CLG_FN_LATCH && (ea | eb)) begin
                refSt[g] <= ea;
            end
            refOut[g] <= res && cnt[g] >= TICK * ((shDly[g] > 120) ? 120 : shDly[g]);
            cnt[g] <= res ? cnt[g] + 1 : 0;
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t word %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t resp %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t gate %b not %b", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        r = bResp;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arReady) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        d = rData;
        r = rResp;
    endtask

    task automatic set_gate(input int g, input logic [31:0] w, input logic [6:0] dl);
        axi_wr(8'(4 * g), w, rsp);
        chk_resp(rsp, 2'h0);
        axi_wr(8'(16 + 4 * g), {25'h0, dl}, rsp);
        chk_resp(rsp, 2'h0);
        shCfg[g] <= '{w[20:16], w[12:8], w[3], w[2], clg_pkg::clg_func_t'(w[1:0])};
        shDly[g] <= dl;
    endtask

    task automatic chk_all();
        repeat (3) @(posedge core_clk);
        for (int g = 0; g < 4; g++) chk_out(gateOut[g], refOut[g]);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_word({28'h0, gateOut}, 32'h0);
        for (int g = 0; g < 4; g++) begin
            axi_rd(8'(4 * g), rd, rsp);
            chk_word(rd, 32'h0);
            axi_rd(8'(16 + 4 * g), rd, rsp);
            chk_word(rd, 32'h0);
        end
        axi_rd(8'h40, rd, rsp);
        chk_resp(rsp, 2'h2);
        axi_wr(8'h20, 32'hF, rsp);
        chk_resp(rsp, 2'h2);
        $display("reset and bus test done");
        set_gate(0, 32'h00090503, 7'h0);
        for (int i = 0; i < 6; i++) begin
            pattern <= (32'(6'b010001 >> i & 1) << 5) | (32'(6'b010100 >> i & 1) << 9);
            chk_all();
            chk_out(gateOut[0], 1'((6'b110011 >> i) & 1));
        end
        axi_rd(8'h20, rd, rsp);
        chk_word(rd, 32'h00000111);
        set_gate(2, 32'h00000702, 7'h0);
        for (int i = 0; i < 2; i++) begin
            pattern <= 32'(i) << 7;
            chk_all();
            chk_out(gateOut[2], 1'(i));
        end
        $display("latch test done");
        for (int i = 0; i < 64; i++) begin
            seed = lfsr(seed);
            set_gate(seed[23:22], (seed & 32'h001F1F00) | 32'(i[3:0]), 7'h0);
            axi_rd(8'({seed[23:22], 2'b00}), rd, rsp);
            chk_word(rd, (seed & 32'h001F1F00) | 32'(i[3:0]));
            seed = lfsr(seed);
            pattern <= seed;
            chk_all();
        end
        $display("random test done");
        for (int k = 0; k < 3; k++) begin
            pattern <= 32'h0;
            set_gate(1, 32'h00040301, (k == 0) ? 7'd0 : (k == 1) ? 7'd2 : 7'h7F);
            chk_all();
            pattern <= 32'h18;
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (gateOut[1] !== 1'b1 && n < 600);
            chk_word(n, (k == 0) ? 3 : (k == 1) ? 11 : 483);
            pattern <= 32'h08;
            chk_all();
        end
        $display("delay test done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
